// file: verilog/isc_top.sv
/*
  Interrupt source control and status: per-source control registers,
  timer status with DMA halt flag, live request view and a small arbiter.
  Assumes a single AHB-Lite master on hclk and pulse inputs from the
  timers, DMA channels and core on the same clock; pins are asynchronous.
*/
`include "isc_params.svh"
`default_nettype none
module isc_top
  import isc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        slave_mode,
  input  wire logic [2:0]  timer_req_pulse,
  input  wire logic [1:0]  dma_done_pulse,
  input  wire logic [1:0]  pin_is_irq,
  input  wire logic        external_irq_five,
  input  wire logic        external_irq_six,
  input  wire logic [4:0]  ext_irq_pin,
  input  wire logic        serial0_enable,
  input  wire logic [6:0]  serial0_conds,
  input  wire logic        serial1_enable,
  input  wire logic [6:0]  serial1_conds,
  input  wire logic        nmi_taken,
  input  wire logic        return_from_interrupt,
  input  wire logic        intr_ack,
  output logic             irq_request,
  output logic      [7:0]  irq_vector,
  output logic             dma_suspend_flag
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  logic [6:0] pin_s3_r;
  logic [6:0] pin_f_r;
  wire  [6:0] pin_raw = {external_irq_six, external_irq_five, ext_irq_pin};
  wire  [6:0] pin_f_nxt = (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r ^ pin_s3_r));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      pin_s3_r <= 7'h00;
      pin_f_r  <= 7'h00;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r  <= pin_f_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave; reads take one wait state so data follow any write
  // ----------------------------------------------------------------------
  isc_bus_t   bus_r;
  logic [7:0] idx_r;
  logic [15:0] rdata;
  wire  accept = hsel && htrans[1] && hready;
  wire  wr_en  = (bus_r == ISC_BUS_WRITE);
  wire  [15:0] wd = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_r     <= ISC_BUS_IDLE;
      idx_r     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else if (bus_r == ISC_BUS_READ && !hreadyout) begin
      hrdata    <= {16'h0000, rdata};
      hreadyout <= 1'b1;
      bus_r     <= ISC_BUS_IDLE;
    end else if (accept) begin
      idx_r     <= haddr[9:2];
      bus_r     <= hwrite ? ISC_BUS_WRITE : ISC_BUS_READ;
      hreadyout <= hwrite;
    end else begin
      bus_r     <= ISC_BUS_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Control registers; source order T0, T1, T2, DMA0, DMA1
  // ----------------------------------------------------------------------
  logic [4:0] blk_r;
  isc_prio_t  prio_r [5];
  isc_prio_t  thr_r;
  // In master mode 038h/03ah belong to other sources and are not mapped here
  wire [4:0] ctl_wr;
  assign ctl_wr[0] = wr_en && idx_r == `ISC_IDX_T0;
  assign ctl_wr[1] = wr_en && idx_r == `ISC_IDX_T1 && slave_mode;
  assign ctl_wr[2] = wr_en && idx_r == `ISC_IDX_T2 && slave_mode;
  assign ctl_wr[3] = wr_en && idx_r == `ISC_IDX_DMA0;
  assign ctl_wr[4] = wr_en && idx_r == `ISC_IDX_DMA1;
  wire mreg_wr = wr_en && idx_r == `ISC_IDX_MASK;
  wire thr_wr = wr_en && idx_r == `ISC_IDX_THR;
  wire [4:0] mreg_view = {wd[3], wd[2], slave_mode ? wd[5] : blk_r[2],
                          slave_mode ? wd[4] : blk_r[1], wd[0]};
  // Either location updates the one stored mask bit; one process owns all of it
  wire [4:0] blk_nxt = (ctl_wr & {5{wd[`ISC_CTRL_BLK]}}) |
                       (~ctl_wr & (mreg_wr ? mreg_view : blk_r));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_r <= {5{`ISC_RST_BLK}};
      for (int k = 0; k < 5; k++) begin
        prio_r[k] <= `ISC_RST_PRIO;
      end
    end else begin
      blk_r <= blk_nxt;
      for (int k = 0; k < 5; k++) begin
        if (ctl_wr[k]) prio_r[k] <= wd[2:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) thr_r <= `ISC_RST_THR;
    else if (thr_wr) thr_r <= wd[2:0];
  end

  // Master mode: the shared register governs all three timers
  function automatic isc_src_t ctl_of(input isc_src_t s, input logic slv);
    ctl_of = (!slv && s < 3'd3) ? 3'd0 : s;
  endfunction : ctl_of

  // ----------------------------------------------------------------------
  // Pending state, status register and halt flag
  // ----------------------------------------------------------------------
  logic [2:0] tpend_r;
  logic [1:0] dpend_r;
  logic [2:0] src_r;
  wire  stat_wr = wr_en && idx_r == `ISC_IDX_STAT;
  wire  [4:0] ack_clr = (intr_ack && irq_request) ? (5'h01 << src_r) : 5'h00;
  wire  [1:0] dsrc;
  assign dsrc[0] = pin_is_irq[0] ? pin_f_r[5] : dma_done_pulse[0];
  assign dsrc[1] = pin_is_irq[1] ? pin_f_r[6] : dma_done_pulse[1];
  // Timer sources set over a clear in the same cycle
  wire  [2:0] tpend_nxt = (stat_wr ? wd[2:0] : (tpend_r & ~ack_clr[2:0])) | timer_req_pulse;
  wire  [1:0] dpend_nxt = (dpend_r & ~ack_clr[4:3]) | dsrc;
  wire  halt_nxt = nmi_taken ? 1'b1 :
                   stat_wr ? wd[`ISC_STAT_HALT] :
                   return_from_interrupt ? 1'b0 : dma_suspend_flag;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tpend_r          <= 3'h0;
      dpend_r          <= 2'h0;
      dma_suspend_flag <= `ISC_RST_HALT;
    end else begin
      tpend_r          <= tpend_nxt;
      dpend_r          <= dpend_nxt;
      dma_suspend_flag <= halt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Live request view, read-only
  // ----------------------------------------------------------------------
  wire ser0 = serial0_enable && |serial0_conds;
  wire ser1 = serial1_enable && |serial1_conds;
  wire [15:0] req_master = {5'h00, ser0, ser1, pin_f_r[4:0], dpend_r, 1'b0, |tpend_r};
  wire [15:0] req_slave  = {10'h000, tpend_r[2], tpend_r[1], dpend_r, 1'b0, tpend_r[0]};
  wire [15:0] req_view   = slave_mode ? req_slave : req_master;
  wire [15:0] mask_rd    = {10'h000, slave_mode ? blk_r[2:1] : 2'b00, blk_r[4:3], 1'b0, blk_r[0]};

  function automatic logic [15:0] ctl_rd(input logic m, input isc_prio_t p);
    ctl_rd = {12'h000, m, p};
  endfunction : ctl_rd

  always_comb begin
    rdata = 16'h0000;
    unique case (idx_r)
      `ISC_IDX_MASK: rdata = mask_rd;
      `ISC_IDX_THR:  rdata = {13'h0000, thr_r};
      `ISC_IDX_REQ:  rdata = req_view;
      `ISC_IDX_STAT: rdata = {dma_suspend_flag, 12'h000, tpend_r};
      `ISC_IDX_T0:   rdata = ctl_rd(blk_r[0], prio_r[0]);
      `ISC_IDX_DMA0: rdata = ctl_rd(blk_r[3], prio_r[3]);
      `ISC_IDX_DMA1: rdata = ctl_rd(blk_r[4], prio_r[4]);
      `ISC_IDX_T1:   rdata = slave_mode ? ctl_rd(blk_r[1], prio_r[1]) : 16'h0000;
      `ISC_IDX_T2:   rdata = slave_mode ? ctl_rd(blk_r[2], prio_r[2]) : 16'h0000;
      default:       rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Arbiter: lowest priority value wins, ties go to the lower source index
  // ----------------------------------------------------------------------
  wire [4:0] pend = {dpend_r, tpend_r};
  logic      found;
  isc_src_t  best;
  isc_prio_t best_p;
  logic [4:0] elig;
  logic [7:0] vec;

  always_comb begin
    found  = 1'b0;
    best   = 3'd0;
    best_p = 3'h7;
    elig   = 5'h00;
    for (int i = 0; i < 5; i++) begin
      elig[i] = pend[i] && !blk_r[ctl_of(3'(i), slave_mode)] &&
                (prio_r[ctl_of(3'(i), slave_mode)] <= thr_r);
      if (elig[i] && (!found || prio_r[ctl_of(3'(i), slave_mode)] < best_p)) begin
        found  = 1'b1;
        best   = 3'(i);
        best_p = prio_r[ctl_of(3'(i), slave_mode)];
      end
    end
  end

  always_comb begin
    unique case (best)
      3'd0:    vec = `ISC_VEC_T0;
      3'd1:    vec = `ISC_VEC_T1;
      3'd2:    vec = `ISC_VEC_T2;
      3'd3:    vec = `ISC_VEC_DMA0;
      default: vec = `ISC_VEC_DMA1;
    endcase
  end

  // Registered answer: a just-acknowledged source drops one cycle late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_request <= 1'b0;
      irq_vector  <= 8'h00;
      src_r       <= 3'd0;
    end else begin
      irq_request <= found;
      irq_vector  <= vec;
      src_r       <= best;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    accept && !hwrite && hreadyout;
  endsequence
  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_t0_vector: assert property (irq_request && src_r == 3'd0 |-> irq_vector == 8'h13)
    else $error("timer0 vector wrong");
  chk_dma1_vector: assert property (irq_request && src_r == 3'd4 |-> irq_vector == 8'h0B)
    else $error("dma1 vector wrong");
  chk_halt_set: assert property (nmi_taken |=> dma_suspend_flag)
    else $error("halt flag not set by nmi");
  chk_halt_clear: assert property (return_from_interrupt && !nmi_taken && !stat_wr |=> !dma_suspend_flag)
    else $error("halt flag not cleared by return");
  chk_timer_sticky: assert property (timer_req_pulse[1] |=> tpend_r[1] [*1])
    else $error("timer request lost");
  chk_req_or: assert property (!slave_mode |-> req_view[0] == |tpend_r)
    else $error("timer or bit wrong");
  // The presented source was chosen one cycle earlier, so judge it by that cycle's state
  chk_mask_block: assert property (irq_request |-> $past(!blk_r[ctl_of(best, slave_mode)]))
    else $error("masked source presented");
  chk_thr_block: assert property (irq_request |-> $past(prio_r[ctl_of(best, slave_mode)] <= thr_r))
    else $error("priority over threshold presented");
  chk_mirror_wr: assert property (mreg_wr && !ctl_wr[0] |=> blk_r[0] == $past(wd[0]))
    else $error("mask mirror not updated");
  chk_read_wait: assert property (s_read_taken |=> s_read_done)
    else $error("read answer timing wrong");

endmodule : isc_top
`default_nettype wire

// file: verilog/isc_params.svh
/*
  Constants of the interrupt source control and status block: register
  indices, field positions, reset values and vector types.
  Assumes it is included by bare name from the design files.
*/
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ISC_IDX_MASK    8'h28
`define ISC_IDX_THR     8'h2A
`define ISC_IDX_REQ     8'h2E
`define ISC_IDX_STAT    8'h30
`define ISC_IDX_T0      8'h32
`define ISC_IDX_DMA0    8'h34
`define ISC_IDX_DMA1    8'h36
`define ISC_IDX_T1      8'h38
`define ISC_IDX_T2      8'h3A

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ISC_CTRL_BLK    3
`define ISC_STAT_HALT   15
`define ISC_RST_BLK     1'b1
`define ISC_RST_PRIO    3'h7
`define ISC_RST_THR     3'h7
`define ISC_RST_HALT    1'b0

// ----------------------------------------------------------------------
// Vector types
// ----------------------------------------------------------------------
`define ISC_VEC_T2      8'h08
`define ISC_VEC_T1      8'h12
`define ISC_VEC_T0      8'h13
`define ISC_VEC_DMA0    8'h0A
`define ISC_VEC_DMA1    8'h0B

`endif

// file: verilog/isc_pkg.sv
/*
  Types of the interrupt source control and status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package isc_pkg;
  typedef logic [2:0] isc_prio_t;
  typedef logic [2:0] isc_src_t;
  typedef enum logic [1:0] {
    ISC_BUS_IDLE,
    ISC_BUS_WRITE,
    ISC_BUS_READ
  } isc_bus_t;
endpackage : isc_pkg
`default_nettype wire

// file: tb/isc_core_model.sv
/*
  Core stand-in: acknowledges a presented interrupt after a chosen delay
  and keeps the vector it took. Assumes the clock and reset of isc_top.
*/
`default_nettype none
module isc_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ack_en,
  input  wire logic [1:0] ack_delay,
  input  wire logic       irq_request,
  input  wire logic [7:0] irq_vector,
  output logic            intr_ack,
  output logic      [7:0] taken_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  logic [1:0] hold_r;
  // Hold-off after an ack, since the request needs two edges to drop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_r    <= 2'h0;
      hold_r    <= 2'h0;
      intr_ack  <= 1'b0;
      taken_vec <= 8'h00;
    end else begin
      intr_ack <= 1'b0;
      if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1;
      end else if (irq_request && ack_en) begin
        if (wait_r == ack_delay) begin
          intr_ack  <= 1'b1;
          taken_vec <= irq_vector;
          wait_r    <= 2'h0;
          hold_r    <= 2'h3;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule : isc_core_model
`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench of isc_top: registers, timers, DMA, pins, halt flag.
  Assumes isc_pkg and isc_core_model are compiled before it.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, r;
  logic [1:0]  htrans = 0, dma_done_pulse = 0, pin_is_irq = 0, ack_delay = 0;
  logic [2:0]  hsize = 3'h2, timer_req_pulse = 0;
  logic [4:0]  ext_irq_pin = 0;
  logic [6:0]  serial0_conds = 0, serial1_conds = 0;
  logic        slave_mode = 0, serial0_enable = 0, serial1_enable = 0, ack_en = 0;
  logic        external_irq_five = 0, external_irq_six = 0, nmi_taken = 0;
  logic        return_from_interrupt = 0, intr_ack, irq_request, dma_suspend_flag;
  logic [7:0]  irq_vector, taken_vec;
  int          errors = 0, comparisons = 0, cyc = 0, i, seed;

  isc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slave_mode(slave_mode),
    .timer_req_pulse(timer_req_pulse), .dma_done_pulse(dma_done_pulse), .pin_is_irq(pin_is_irq),
    .external_irq_five(external_irq_five), .external_irq_six(external_irq_six),
    .ext_irq_pin(ext_irq_pin), .serial0_enable(serial0_enable), .serial0_conds(serial0_conds),
    .serial1_enable(serial1_enable), .serial1_conds(serial1_conds), .nmi_taken(nmi_taken),
    .return_from_interrupt(return_from_interrupt), .intr_ack(intr_ack),
    .irq_request(irq_request), .irq_vector(irq_vector), .dma_suspend_flag(dma_suspend_flag));
  isc_core_model core (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en), .ack_delay(ack_delay),
    .irq_request(irq_request), .irq_vector(irq_vector), .intr_ack(intr_ack), .taken_vec(taken_vec));

  always #2.5 hclk = ~hclk;

  // ----------------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Read data is taken at the edge that samples hready high in the data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, q);
    chk(n, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic kick(input logic [2:0] t, input logic [1:0] d, input logic n, input logic f);
    @(posedge hclk);
    timer_req_pulse       <= t;
    dma_done_pulse        <= d;
    nmi_taken             <= n;
    return_from_interrupt <= f;
    @(posedge hclk);
    timer_req_pulse       <= 3'h0;
    dma_done_pulse        <= 2'h0;
    nmi_taken             <= 1'b0;
    return_from_interrupt <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : kick

  task automatic serve;
    ack_delay <= 2'($random(seed));
    ack_en    <= 1'b1;
    repeat (20) @(posedge hclk);
    ack_en    <= 1'b0;
  endtask : serve

  function automatic logic [31:0] exp_vec(input int s);
    case (s)
      0:       return 32'h13;
      1:       return 32'h12;
      default: return 32'h08;
    endcase
  endfunction : exp_vec

  function automatic logic [31:0] exp_req(input logic [31:0] v);
    return {21'h0, v[12] & (|v[11:5]), v[20] & (|v[19:13]), v[4:0], 4'h4};
  endfunction : exp_req

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 29795;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("t0_ctrl", 32'hC8, 32'h0000_000F);
    rchk("dma0_ctrl", 32'hD0, 32'h0000_000F);
    rchk("dma1_ctrl", 32'hD8, 32'h0000_000F);
    rchk("threshold", 32'hA8, 32'h0000_0007);
    rchk("t1_master", 32'hE0, 32'h0);
    rchk("unmapped", 32'h1FC, 32'h0);
    ahb(1'b1, 32'hB8, 32'h0000_FFFF, q);
    rchk("req_ro", 32'hB8, 32'h0);
    slave_mode <= 1'b1;
    rchk("t1_slave", 32'hE0, 32'h0000_000F);
    rchk("t2_slave", 32'hE8, 32'h0000_000F);
    slave_mode <= 1'b0;
    ahb(1'b1, 32'hC8, 32'h0, q);
    for (i = 0; i < 3; i++) begin
      kick(3'h1 << i, 2'h0, 1'b0, 1'b0);
      chk("irq_req", 32'h1, {31'h0, irq_request});
      chk("irq_vec", exp_vec(i), {24'h0, irq_vector});
      rchk("status", 32'hC0, 32'h1 << i);
      rchk("req_tmr", 32'hB8, 32'h1);
      serve();
      chk("taken", exp_vec(i), {24'h0, taken_vec});
      rchk("status_clr", 32'hC0, 32'h0);
    end
    ahb(1'b1, 32'hA0, 32'h0000_000D, q);
    rchk("t0_mirror", 32'hC8, 32'h0000_0008);
    kick(3'h1, 2'h0, 1'b0, 1'b0);
    chk("masked", 32'h0, {31'h0, irq_request});
    ahb(1'b1, 32'hC0, 32'h0, q);
    ahb(1'b1, 32'hD0, 32'h2, q);
    ahb(1'b1, 32'hD8, 32'h1, q);
    kick(3'h0, 2'h3, 1'b0, 1'b0);
    chk("prio_win", 32'h0B, {24'h0, irq_vector});
    rchk("req_dma", 32'hB8, 32'h0000_000C);
    ahb(1'b1, 32'hA8, 32'h0, q);
    repeat (3) @(posedge hclk);
    chk("thr_block", 32'h0, {31'h0, irq_request});
    ahb(1'b1, 32'hA8, 32'h7, q);
    serve();
    chk("dma0_vec", 32'h0A, {24'h0, taken_vec});
    chk("dma_idle", 32'h0, {31'h0, irq_request});
    pin_is_irq        <= 2'h1;
    external_irq_five <= 1'b1;
    for (i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'h0000_1000 : $random(seed);
      ext_irq_pin    <= r[4:0];
      serial0_conds  <= r[11:5];
      serial0_enable <= r[12];
      serial1_conds  <= r[19:13];
      serial1_enable <= r[20];
      repeat (8) @(posedge hclk);
      rchk("req_view", 32'hB8, exp_req(r));
    end
    kick(3'h0, 2'h0, 1'b1, 1'b0);
    chk("halt_nmi", 32'h1, {31'h0, dma_suspend_flag});
    kick(3'h0, 2'h0, 1'b0, 1'b1);
    chk("halt_ret", 32'h0, {31'h0, dma_suspend_flag});
    ahb(1'b1, 32'hC0, 32'h0000_8000, q);
    rchk("halt_sw", 32'hC0, 32'h0000_8000);
    chk("halt_out", 32'h1, {31'h0, dma_suspend_flag});
    slave_mode <= 1'b1;
    ahb(1'b1, 32'hA0, 32'h0000_002D, q);
    rchk("mask_slave", 32'hA0, 32'h0000_002D);
    rchk("t1_unmask", 32'hE0, 32'h0000_0007);
    kick(3'h6, 2'h0, 1'b0, 1'b0);
    chk("slave_req", 32'h1, {31'h0, irq_request});
    chk("slave_vec", 32'h12, {24'h0, irq_vector});
    rchk("req_slave", 32'hB8, 32'h0000_0034);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
